// file: hw/cc_regs.vh
`ifndef CC_REGS_VH
`define CC_REGS_VH

// module count
`define NUM_MODULES 5
`define WDT_MODULE 4

// register map, byte addresses; module n at base + 4*n
`define ADDR_MODE_BASE 8'h00
`define ADDR_CMP_LOW_BASE 8'h20
`define ADDR_CMP_HIGH_BASE 8'h40
`define ADDR_COUNTER 8'h60
`define ADDR_CONTROL 8'h64
`define ADDR_STATUS 8'h68
`define ADDR_MASK 8'h6c

// mode register fields
`define MODE_RESET 8'h00
`define MODE_COMPARATOR 6
`define MODE_RISING 5
`define MODE_FALLING 4
`define MODE_MATCH 3
`define MODE_TOGGLE 2
`define MODE_PWM 1
`define MODE_IRQ_EN 0

// control register fields
`define CTRL_RUN 0
`define CTRL_WATCHDOG 1
`define CTRL_RESET 2'h0
`endif

// file: hw/cc_slot.v
`timescale 1ns/1ps
`include "cc_regs.vh"
module cc_slot
(
  // clock and reset
  input wire clk,
  input wire rst,
  // configuration
  input wire [7:0] mode,
  input wire [15:0] counter,
  input wire count_en,
  // software writes to compare bytes
  input wire low_wr,
  input wire high_wr,
  input wire [7:0] wdata,
  // pin
  input wire pin_in,
  output reg pin_out,
  // state
  output reg [7:0] compare_low_byte,
  output reg [7:0] compare_high_byte,
  output wire match,
  output wire event_pulse
);
  reg sync0;
  reg sync1;
  reg sync_prev;
  wire rise;
  wire fall;
  wire cap;
  wire cmp_en;
  wire pwm;
  wire wrap;

  // ----------------------------------------
  // capture input
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (rst)
    begin
      sync0 <= 1'b0;
      sync1 <= 1'b0;
      sync_prev <= 1'b0;
    end
    else
    begin
      sync0 <= pin_in;
      sync1 <= sync0;
      sync_prev <= sync1;
    end
  end

  assign rise = sync1 & ~sync_prev;
  assign fall = ~sync1 & sync_prev;
  assign cap = (mode[`MODE_RISING] & rise) | (mode[`MODE_FALLING] & fall);
  assign cmp_en = mode[`MODE_COMPARATOR];
  assign pwm = mode[`MODE_PWM];
  // compare only on a counting cycle so one count gives one event
  assign match = cmp_en & count_en & ~pwm
    & (counter == {compare_high_byte, compare_low_byte});
  assign event_pulse = cap | (match & mode[`MODE_MATCH]);
  assign wrap = count_en & (counter[7:0] == 8'hff);

  // ----------------------------------------
  // compare registers and pin
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (rst)
    begin
      compare_low_byte <= 8'h00;
      compare_high_byte <= 8'h00;
      pin_out <= 1'b0;
    end
    else
    begin
      if (cap)
      begin
        compare_low_byte <= counter[7:0];
        compare_high_byte <= counter[15:8];
      end
      else
      begin
        if (low_wr)
          compare_low_byte <= wdata;
        else if (pwm & cmp_en & wrap)
          compare_low_byte <= compare_high_byte;
        if (high_wr)
          compare_high_byte <= wdata;
      end
      if (pwm & cmp_en)
        pin_out <= (counter[7:0] >= compare_low_byte);
      else if (match & mode[`MODE_TOGGLE])
        pin_out <= ~pin_out;
    end
  end
endmodule // cc_slot

// file: hw/cc_array.v
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "cc_regs.vh"
module cc_array
(
  // clock and reset
  input wire clk,
  input wire rst,
  // register port
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  // counter time base
  input wire count_en,
  // module pins
  input wire [4:0] module_pin_in,
  output wire [4:0] module_pin,
  // interrupt and watchdog
  output wire irq,
  output reg internal_reset
);
  reg [15:0] counter;
  reg [1:0] counter_control_reg;
  reg [39:0] mode_flat;
  reg [4:0] module_event_flag;
  reg [4:0] irq_mask;
  wire [39:0] low_flat;
  wire [39:0] high_flat;
  wire [4:0] match;
  wire [4:0] ev;
  wire tick;
  wire [2:0] slot;
  wire in_mode;
  wire in_low;
  wire in_high;
  wire [4:0] irq_en;
  integer i;

  assign tick = count_en & counter_control_reg[`CTRL_RUN];
  assign slot = addr[4:2];
  assign in_mode = (addr[7:5] == 3'h0) & (slot < 3'h5) & (addr[1:0] == 2'h0);
  assign in_low = (addr[7:5] == 3'h1) & (slot < 3'h5) & (addr[1:0] == 2'h0);
  assign in_high = (addr[7:5] == 3'h2) & (slot < 3'h5) & (addr[1:0] == 2'h0);

  // ----------------------------------------
  // modules on one shared counter
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < `NUM_MODULES; g = g + 1)
    begin : mod
      cc_slot u_slot
      (
        .clk(clk),
        .rst(rst),
        .mode(mode_flat[g*8 +: 8]),
        .counter(counter),
        .count_en(tick),
        .low_wr(wr & in_low & (slot == g)),
        .high_wr(wr & in_high & (slot == g)),
        .wdata(wdata),
        .pin_in(module_pin_in[g]),
        .pin_out(module_pin[g]),
        .compare_low_byte(low_flat[g*8 +: 8]),
        .compare_high_byte(high_flat[g*8 +: 8]),
        .match(match[g]),
        .event_pulse(ev[g])
      );
      assign irq_en[g] = mode_flat[g*8 + `MODE_IRQ_EN];
    end
  endgenerate

  // ----------------------------------------
  // counter, registers, flags
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (rst)
    begin
      counter <= 16'h0000;
      counter_control_reg <= `CTRL_RESET;
      mode_flat <= {5{`MODE_RESET}};
      module_event_flag <= 5'h00;
      irq_mask <= 5'h00;
    end
    else
    begin
      if (wr & (addr == `ADDR_COUNTER))
        counter <= {8'h00, wdata};
      else if (tick)
        counter <= counter + 16'h0001;
      if (wr & (addr == `ADDR_CONTROL))
        counter_control_reg <= wdata[1:0];
      if (wr & in_mode)
      begin
        for (i = 0; i < `NUM_MODULES; i = i + 1)
          if (slot == i)
            mode_flat[i*8 +: 8] <= {1'b0, wdata[6:0]};
      end
      if (wr & (addr == `ADDR_MASK))
        irq_mask <= wdata[4:0];
      // a new event wins over a simultaneous write-one clear
      if (wr & (addr == `ADDR_STATUS))
        module_event_flag <= (module_event_flag & ~wdata[4:0]) | ev;
      else
        module_event_flag <= module_event_flag | ev;
    end
  end

  // both the per-module mode enable bit and the module's bit in the mask register must pass
  assign irq = |(module_event_flag & irq_en & irq_mask);

  // ----------------------------------------
  // watchdog on module 4 only
  // ----------------------------------------
  // one-cycle pulse; the external reset pin is left untouched
  always @(posedge clk)
  begin
    if (rst)
      internal_reset <= 1'b0;
    else
      internal_reset <= counter_control_reg[`CTRL_WATCHDOG]
        & match[`WDT_MODULE];
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (rst)
      rdata <= 8'h00;
    else if (rd)
    begin
      rdata <= 8'h00;
      if (in_mode)
        rdata <= mode_flat[slot*8 +: 8];
      else if (in_low)
        rdata <= low_flat[slot*8 +: 8];
      else if (in_high)
        rdata <= high_flat[slot*8 +: 8];
      else if (addr == `ADDR_COUNTER)
        rdata <= counter[7:0];
      else if (addr == `ADDR_CONTROL)
        rdata <= {6'h00, counter_control_reg};
      else if (addr == `ADDR_STATUS)
        rdata <= {3'h0, module_event_flag};
      else if (addr == `ADDR_MASK)
        rdata <= {3'h0, irq_mask};
    end
  end
endmodule // cc_array

// file: dv/pin_model.sv
`timescale 1ns/1ps
module pin_model
(
  // pins
  input wire clk,
  input wire [4:0] level,
  output logic [4:0] pins
);
  // registered so edges land just after a clock edge
  initial pins = 5'h00;
  always @(posedge clk) pins <= level;
endmodule // pin_model

// file: dv/cc_array_props.sv
`timescale 1ns/1ps
module cc_array_props
(
  // bus
  input wire clk,
  input wire rst,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata,
  // pins and events
  input wire count_en,
  input wire [4:0] module_pin_in,
  input wire [4:0] module_pin,
  input wire irq,
  input wire internal_reset
);
  // ----
  // checks
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence wr_at(a);
    wr && addr == a;
  endsequence
  AST_RST_IDLE: assert property (disable iff (1'b0) rst |=> !irq && !internal_reset)
    else $error("busy after reset");
  AST_MODE_TOP: assert property (rd && addr == 8'h00 |=> !rdata[7])
    else $error("mode top bit set");
  AST_RD_HOLD: assert property (!rd |=> $stable(rdata))
    else $error("read data moved");
  AST_IRQ_MASK: assert property (wr_at(8'h6c) ##0 wdata == 8'h00 |=> !irq)
    else $error("irq while masked");
  AST_WD_OFF: assert property (wr_at(8'h64) ##0 !wdata[1] |=> ##1 !internal_reset)
    else $error("reset while disarmed");
  AST_WD_TICK: assert property (internal_reset |-> $past(count_en))
    else $error("reset without count");
  AST_WD_PULSE: assert property (internal_reset |=> !internal_reset)
    else $error("reset too long");
  // pins move only after a count or a register write
  AST_PIN_CAUSE: assert property (!$stable(module_pin) |->
    $past(count_en) || $past(wr) || $past(count_en, 2) || $past(wr, 2))
    else $error("pin moved alone");
endmodule // cc_array_props

// file: dv/cc_array_bench.sv
`timescale 1ns/1ps
module cc_array_bench;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, count_en = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d;
  logic [4:0] level = 5'h00, pin_in, pin_out;
  logic irq, internal_reset;
  int n_errors = 0, total_checks = 0, cycles = 0, wd_count = 0;
  pin_model far (.clk(clk), .level(level), .pins(pin_in));
  cc_array dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .count_en(count_en), .module_pin_in(pin_in), .module_pin(pin_out),
    .irq(irq), .internal_reset(internal_reset));
  initial forever #2.5 clk = ~clk;
  // ----
  // helpers
  // ----
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (internal_reset === 1'b1)
      wd_count <= wd_count + 1;
    if (cycles == 3000)
    begin
      n_errors = n_errors + 1;
      print_verdict;
    end
  end
  task chk(string what, logic [7:0] seen, logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // idle cycle after each strobe keeps drivers to one change per step
  task wreg(logic [7:0] a, logic [7:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task rreg(logic [7:0] a);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask
  task tick(int n);
    repeat (n)
    begin
      count_en <= 1'b1;
      @(posedge clk);
    end
    count_en <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task cap(logic lvl, logic [7:0] c, logic [7:0] exp);
    wreg(8'h60, c);
    level[1] <= lvl;
    repeat (6) @(posedge clk);
    rreg(8'h24);
    chk("capture", d, exp);
  endtask
  // ----
  // scenarios
  // ----
  task t_reset;
    for (int i = 0; i < 5; i++)
    begin
      rreg(8'(4 * i));
      chk("mode", d, 8'h00);
    end
    wreg(8'h00, 8'h7f);
    rreg(8'h00);
    chk("mode top", d, 8'h7f);
    $display("reset done");
  endtask
  task t_timer;
    wreg(8'h20, 8'h12);
    wreg(8'h60, 8'h10);
    wreg(8'h6c, 8'h01);
    wreg(8'h00, 8'h49);
    wreg(8'h64, 8'h01);
    tick(4);
    rreg(8'h68);
    chk("flag", d, 8'h01);
    chk("irq", 8'(irq), 8'h01);
    wreg(8'h6c, 8'h00);
    chk("irq masked", 8'(irq), 8'h00);
    wreg(8'h64, 8'h00);
    wreg(8'h68, 8'h1f);
    $display("timer done");
  endtask
  task t_capture;
    wreg(8'h04, 8'h20);
    cap(1'b1, 8'h55, 8'h55);
    cap(1'b0, 8'h66, 8'h55);
    wreg(8'h04, 8'h10);
    cap(1'b1, 8'h77, 8'h55);
    cap(1'b0, 8'h88, 8'h88);
    wreg(8'h04, 8'h30);
    cap(1'b1, 8'h99, 8'h99);
    cap(1'b0, 8'haa, 8'haa);
    // run one count across the low byte so the high byte is not zero
    wreg(8'h60, 8'hff);
    wreg(8'h64, 8'h01);
    tick(1);
    wreg(8'h64, 8'h00);
    level[1] <= 1'b1;
    repeat (6) @(posedge clk);
    rreg(8'h44);
    chk("capture high", d, 8'h01);
    rreg(8'h24);
    chk("capture low", d, 8'h00);
    $display("capture done");
  endtask
  task t_pwm;
    wreg(8'h2c, 8'h80);
    wreg(8'h4c, 8'h20);
    wreg(8'h0c, 8'h42);
    wreg(8'h60, 8'h80);
    @(posedge clk);
    chk("pwm equal", 8'(pin_out[3]), 8'h01);
    wreg(8'h60, 8'h7f);
    @(posedge clk);
    chk("pwm below", 8'(pin_out[3]), 8'h00);
    wreg(8'h60, 8'hff);
    wreg(8'h64, 8'h01);
    tick(1);
    wreg(8'h64, 8'h00);
    rreg(8'h2c);
    chk("pwm reload", d, 8'h20);
    $display("pwm done");
  endtask
  task t_watchdog;
    wreg(8'h30, 8'h05);
    wreg(8'h10, 8'h4c);
    wreg(8'h60, 8'h03);
    wreg(8'h64, 8'h03);
    tick(4);
    chk("wd reset", 8'(wd_count), 8'h01);
    chk("toggle", 8'(pin_out[4]), 8'h01);
    wreg(8'h60, 8'h03);
    tick(1);
    // serviced from the main flow, never from an interrupt handler
    wreg(8'h30, 8'h40);
    tick(3);
    chk("wd serviced", 8'(wd_count), 8'h01);
    wreg(8'h30, 8'h05);
    wreg(8'h60, 8'h03);
    wreg(8'h64, 8'h01);
    tick(4);
    chk("wd off", 8'(wd_count), 8'h01);
    chk("toggle back", 8'(pin_out[4]), 8'h00);
    $display("watchdog done");
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_timer;
    t_capture;
    t_pwm;
    t_watchdog;
    print_verdict;
  end
endmodule // cc_array_bench
bind cc_array cc_array_props props (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .count_en(count_en), .module_pin_in(module_pin_in),
  .module_pin(module_pin), .irq(irq), .internal_reset(internal_reset));
